// file: verilog/sleep_entry_params.svh
`ifndef SLEEP_ENTRY_PARAMS_SVH
`define SLEEP_ENTRY_PARAMS_SVH
`define SLEEP_ID_BYTE 8'h86
`define BITS_PER_BYTE 4'h8
`define RECOVERY_TIME_US 400
`define CLOCK_MHZ 100
`define RECOVERY_CYCLES (`RECOVERY_TIME_US * `CLOCK_MHZ)
`endif

// file: verilog/sleep_entry_pkg.sv
package sleep_entry_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_ACK,
		ST_IGNORE,
		ST_SLEEP
	} entry_state_t;
endpackage

// file: verilog/sync_edge.sv
`timescale 1ns/1ps
module sync_edge (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_level = sync_r;
	assign o_rise = sync_r & ~prev_r;
	assign o_fall = ~sync_r & prev_r;
endmodule

// file: verilog/i2c_sleep_entry_sda_release.sv
`timescale 1ns/1ps
`include "sleep_entry_params.svh"
module i2c_sleep_entry_sda_release
	import sleep_entry_pkg::*;
#(
	parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_sleep_armed,
	output logic o_sda,
	output logic o_sda_oe_n,
	output logic o_sleeping,
	output logic o_ready,
	output logic o_stop_seen
);
	logic scl;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	logic sda_rise;
	logic sda_fall;
	entry_state_t state_r;
	entry_state_t state_nxt;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic drive_low_r;
	logic [31:0] rec_cnt_r;
	logic [31:0] rec_nxt;
	logic stop_seen_r;
	logic sleeping_r;
	logic ready_r;

	logic start;
	logic stop;
	logic byte_done;
	logic sleep_hit;
	logic ack_done;
	logic wake_ok;
	logic frame_open;

	sync_edge u_scl (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async(i_scl),
		.o_level(scl),
		.o_rise(scl_rise),
		.o_fall(scl_fall)
	);

	sync_edge u_sda (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async(i_sda),
		.o_level(sda),
		.o_rise(sda_rise),
		.o_fall(sda_fall)
	);

	assign start = scl & sda_fall;
	// SDA rising with SCL high, including our own sleep release
	assign stop = scl & sda_rise;

	// Eighth data bit ends on its SCL fall
	assign byte_done = scl_fall && (bit_cnt_r == `BITS_PER_BYTE);
	assign sleep_hit = i_sleep_armed && (shift_r == `SLEEP_ID_BYTE);

	// Ninth SCL rise while acknowledging ends the frame
	assign ack_done = (state_r == ST_ACK) && scl_rise;
	assign wake_ok = (rec_cnt_r == 32'h0);

	// START is ignored in sleep until recovery has run out
	assign frame_open = start && ((state_r != ST_SLEEP) || wake_ok);

	// Next state of the frame sequencer
	always_comb begin
		state_nxt = state_r;
		if (frame_open) begin
			state_nxt = ST_SHIFT;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					state_nxt = ST_IDLE;
				end
				ST_SHIFT: begin
					if (stop) begin
						state_nxt = ST_IDLE;
					end else if (byte_done && sleep_hit) begin
						state_nxt = ST_ACK;
					end else if (byte_done) begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_ACK: begin
					if (scl_rise) begin
						state_nxt = ST_SLEEP;
					end
				end
				ST_IGNORE: begin
					if (stop) begin
						state_nxt = ST_IDLE;
					end
				end
				ST_SLEEP: begin
					state_nxt = ST_SLEEP;
				end
			endcase
		end
	end

	// Frame sequencer state
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Byte shifter, MSB first on synced SCL rise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			shift_r <= 8'h00;
		end else if (frame_open) begin
			shift_r <= 8'h00;
		end else if (state_r == ST_SHIFT && !stop && scl_rise) begin
			shift_r <= {shift_r[6:0], sda};
		end
	end

	// Bit counter within the byte
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			bit_cnt_r <= 4'h0;
		end else if (frame_open) begin
			bit_cnt_r <= 4'h0;
		end else if (state_r == ST_SHIFT && !stop) begin
			if (scl_rise) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (byte_done) begin
				bit_cnt_r <= 4'h0;
			end
		end
	end

	// SDA drive: low only while acknowledging, released on ninth rise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			drive_low_r <= 1'b0;
		end else if (ack_done) begin
			drive_low_r <= 1'b0;
		end else if (state_r == ST_SHIFT && !stop && byte_done && sleep_hit) begin
			drive_low_r <= 1'b1;
		end
	end

	// Recovery count, loaded as sleep begins
	always_comb begin
		rec_nxt = rec_cnt_r;
		if (ack_done) begin
			rec_nxt = 32'(RECOVERY_CYCLES);
		end else if (rec_cnt_r != 32'h0) begin
			rec_nxt = rec_cnt_r - 32'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rec_cnt_r <= 32'h0;
		end else begin
			rec_cnt_r <= rec_nxt;
		end
	end

	// Status outputs from flops, aligned with the state register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sleeping_r <= 1'b0;
			ready_r <= 1'b1;
		end else begin
			sleeping_r <= (state_nxt == ST_SLEEP);
			ready_r <= (state_nxt != ST_SLEEP) || (rec_nxt == 32'h0);
		end
	end

	// Sticky STOP observation, cleared by next START
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			stop_seen_r <= 1'b0;
		end else if (stop) begin
			stop_seen_r <= 1'b1;
		end else if (start) begin
			stop_seen_r <= 1'b0;
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe_n = ~drive_low_r;
	assign o_sleeping = sleeping_r;
	assign o_ready = ready_r;
	assign o_stop_seen = stop_seen_r;
endmodule

// file: tb/sleep_monitor.sv
`timescale 1ns/1ps
module sleep_monitor(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic o_sda_oe_n,
	input wire logic o_sleeping,
	input wire logic o_ready,
	input wire logic o_stop_seen,
	input wire logic i_sda
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	a_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
		else $error("ack began with scl high");
	a_free_scl_high: assert property ($rose(o_sda_oe_n) |-> i_scl)
		else $error("release not in ninth high");
	a_sleep_busy: assert property ($rose(o_sleeping) |-> !o_ready)
		else $error("ready while asleep");
	a_stop_flag: assert property (i_scl && $rose(i_sda) |-> ##[1:8] o_stop_seen)
		else $error("stop missed");
	c_sleep: cover property ($rose(o_sleeping));
	c_stop: cover property ($rose(o_stop_seen));
	c_wake: cover property ($rose(o_ready));
endmodule
bind i2c_sleep_entry_sda_release sleep_monitor mon(.*);

// file: tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model(
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	output logic ack
);
	initial begin
		scl = 1;
		sda_low = 0;
		ack = 0;
	end
	// START, byte MSB first, ninth clock; SCL left low
	task send(input logic [7:0] b, input logic hold);
		sda_low = 1;
		#60 scl = 0;
		for (int i = 0; i < 9; i++) begin
			#30 sda_low = i < 8 && !b[7-i];
			#32 scl = 1;
			if (i == 8) ack = !sda;
			if (i == 8) sda_low = hold;
			#63 scl = 0;
		end
		#100;
	endtask
	// Own STOP; a slave-made one is ignored
	task stop();
		#30 sda_low = 1;
		#32 scl = 1;
		#63 sda_low = 0;
		#60;
	endtask
endmodule

// file: tb/i2c_sleep_entry_sda_release_test.sv
`timescale 1ns/1ps
module i2c_sleep_entry_sda_release_test;
	logic i_clock = 0, i_rst = 1, arm = 0;
	logic o_sda, oe_n, o_sleeping, o_ready, o_stop_seen, scl, m_low, ack;
	wire sda = !(m_low || !oe_n);
	wire [3:0] seen = {ack, o_sleeping, o_ready, o_stop_seen};
	int bad_count = 0, checked = 0;
	logic [3:0] exp_q[$];
	event got;
	initial forever #5 i_clock = !i_clock;
	i2c_master_model mdl(.sda(sda), .scl(scl), .sda_low(m_low), .ack(ack));
	i2c_sleep_entry_sda_release #(.RECOVERY_CYCLES(50)) uut(.i_clock(i_clock),
		.i_rst(i_rst), .i_scl(scl), .i_sda(sda), .i_sleep_armed(arm), .o_sda(o_sda),
		.o_sda_oe_n(oe_n), .o_sleeping(o_sleeping), .o_ready(o_ready),
		.o_stop_seen(o_stop_seen));
	task check(input logic [3:0] s, input logic [3:0] w);
		checked++;
		if (s !== w) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, w);
		end
	endtask
	task results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task frame(input logic a, input logic [7:0] b, input logic h, input logic [3:0] w);
		@(negedge i_clock) arm = a;
		exp_q.push_back(w);
		mdl.send(b, h);
		->got;
		#1 mdl.stop();
	endtask
	initial forever @(got) begin
		check(seen, exp_q.pop_front());
		check({3'h0, o_sda}, 4'h0);
	end
	initial begin
		logic [7:0] r;
		void'($urandom(32'h6D9CCC19));
		repeat (4) @(negedge i_clock);
		i_rst = 0;
		repeat (3) @(negedge i_clock);
		for (int h = 0; h < 2; h++) begin
			r = 8'($urandom);
			if (r == 8'h86)
				r = 8'h87;
			frame(0, 8'h86, 0, 4'h2);
			frame(1, r, 0, 4'h2);
			frame(1, 8'h86, h[0], {3'h6, !h[0]});
			for (int n = 0; o_ready !== 1'b1; n++) begin
				if (n > 200) begin
					bad_count++;
					results();
				end
				@(negedge i_clock);
			end
			$display("test %0d done", h);
		end
		results();
	end
endmodule
